// File: rtl/shd_params.svh
`ifndef SHD_PARAMS_SVH
`define SHD_PARAMS_SVH
// ****************************************
// Timing
// ****************************************
`define SHD_CLK_KHZ      32'h0003_0D40
`define SHD_OSC_FAST_KHZ 32'h0000_0064
`define SHD_OSC_SLOW_KHZ 32'h0000_0050
`define SHD_STEPS        7'h64
`define SHD_PCT_FAST_CYC (`SHD_CLK_KHZ / (`SHD_OSC_FAST_KHZ * 32'(`SHD_STEPS)))
`define SHD_PCT_SLOW_CYC (`SHD_CLK_KHZ / (`SHD_OSC_SLOW_KHZ * 32'(`SHD_STEPS)))
`define SHD_WAKE_MS      0.5
`define SHD_ACT_DLY_CYC  3'h4
`define SHD_MIN_DUTY     7'h04
`define SHD_MAX_DUTY     7'h60
// ****************************************
// Register offsets
// ****************************************
`define SHD_A_STATUS     8'h00
`define SHD_A_CFG0       8'h04
`define SHD_A_CFG7       8'h20
`define SHD_A_FAULT      8'h24
// ****************************************
// Fields
// ****************************************
`define SHD_ST_FREQ      8
`define SHD_ST_READY     9
`define SHD_CF_HIT       0
`define SHD_CF_HOLD      8
`define SHD_CF_THIT      16
`define SHD_CF_DIV       24
`define SHD_CF_MODE      26
`define SHD_CF_SRC       27
`define SHD_CF_HS        28
`define SHD_CF_BR        29
`define SHD_CFG_RST      32'h0000_0000
`endif

// File: rtl/shd_pkg.sv
`include "shd_params.svh"
package shd_pkg;
   // One-hot drive phase per channel
   typedef enum logic [5:0]
   {
      PH_IDLE = 6'h01,
      PH_DLY  = 6'h02,
      PH_RAMP = 6'h04,
      PH_HIT  = 6'h08,
      PH_FALL = 6'h10,
      PH_HOLD = 6'h20
   } shd_ph_t;
   // Half-bridge pairing of an even/odd pair
   typedef enum logic [1:0]
   {
      BR_SINGLE = 2'h0,
      BR_PAR    = 2'h1,
      BR_FULL   = 2'h2
   } shd_br_t;
   // Time base state
   typedef struct packed
   {
      logic [4:0] cnt;
      logic       pct;
   } shd_tb_st_t;
   // Sequencer state
   typedef struct packed
   {
      logic               en_s1;
      logic               en_s2;
      logic               te_s1;
      logic               te_s2;
      logic               to_s1;
      logic               to_s2;
      logic [7:0]         cs_s1;
      logic [7:0]         cs_s2;
      logic [19:0]        wake;
      logic               ready;
      logic [7:0][31:0]   cfg;
      logic [7:0]         on_bits;
      logic               freq;
      logic [7:0]         fault;
      logic [31:0]        rdata;
      shd_ph_t [7:0]      ph;
      logic [7:0][1:0]    dly;
      logic [7:0][7:0]    thit;
      logic [7:0][8:0]    phase;
      logic [7:0]         pon;
      logic [7:0]         drv;
      logic [7:0]         hs;
      logic [7:0]         hitt;
      logic [7:0][6:0]    refc;
      logic               fault_n;
   } shd_top_st_t;
   // Reset image of the sequencer
   function automatic shd_top_st_t top_rst();
      shd_top_st_t s;
      s = '0;
      s.fault_n = 1'b1;
      for (int c = 0; c < 8; c++)
      begin
         s.ph[c] = PH_IDLE;
         s.cfg[c] = `SHD_CFG_RST;
      end
      return s;
   endfunction : top_rst
   // Percent steps per chop period: 11 -> x1 ... 00 -> x4
   function automatic logic [8:0] chop_len(input logic [1:0] sel);
      logic [2:0] dv;
      dv = 3'h4 - {1'b0, sel};
      return 9'(dv) * 9'(`SHD_STEPS);
   endfunction : chop_len
   // On-count for a duty in percent, clamped to the duty window
   function automatic logic [8:0] duty_cnt(input logic [6:0] pct, input logic [1:0] sel);
      logic [6:0] p;
      logic [2:0] dv;
      dv = 3'h4 - {1'b0, sel};
      if (pct == 7'h00)
         p = 7'h00;
      else if (pct >= `SHD_STEPS)
         p = `SHD_STEPS;
      else if (pct < `SHD_MIN_DUTY)
         p = `SHD_MIN_DUTY;
      else if (pct >= `SHD_MAX_DUTY)
         p = `SHD_MAX_DUTY;
      else
         p = pct;
      return 9'(p) * 9'(dv);
   endfunction : duty_cnt
   // Channel register window decode
   function automatic logic is_cfg(input logic [7:0] a);
      return (a >= `SHD_A_CFG0) && (a <= `SHD_A_CFG7) && (a[1:0] == 2'h0);
   endfunction : is_cfg
   function automatic logic [2:0] cfg_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `SHD_A_CFG0;
      return d[4:2];
   endfunction : cfg_idx
endpackage : shd_pkg

// File: rtl/shd_tb_if.sv
`timescale 1ns/100ps
// Time base link between sequencer and divider
interface shd_tb_if;
   logic run;       // Divider runs while high
   logic freq_sel;  // Low 100 kHz, high 80 kHz
   logic pct_tick;  // One percent of an oscillator period
   modport src (input run, input freq_sel, output pct_tick);
   modport snk (output run, output freq_sel, input pct_tick);
endinterface : shd_tb_if

// File: rtl/shd_timebase.sv
`timescale 1ns/100ps
`include "shd_params.svh"
module shd_timebase
(
   input wire logic clk,
   input wire logic srst,
   shd_tb_if.src    tb
);
   shd_pkg::shd_tb_st_t r_r;   // Registered state
   shd_pkg::shd_tb_st_t r_nxt; // Next state
   logic [4:0]          lim;   // Last count of a step
   // ****************************************
   // Step divider
   // ****************************************
   // Emulated oscillator: 100 steps per period
   always_comb
   begin
      r_nxt = r_r;
      r_nxt.pct = 1'b0;
      // Slow oscillator needs a longer step
      lim = tb.freq_sel ? 5'(`SHD_PCT_SLOW_CYC - 1) : 5'(`SHD_PCT_FAST_CYC - 1);
      if (!tb.run)
         r_nxt.cnt = 5'h00;
      else if (r_r.cnt >= lim)
      begin
         // Compare with >= so a rate change never overruns
         r_nxt.cnt = 5'h00;
         r_nxt.pct = 1'b1;
      end
      else
         r_nxt.cnt = r_r.cnt + 5'h01;
   end
   // State register
   always_ff @(posedge clk)
   begin
      if (srst)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end
   assign tb.pct_tick = r_r.pct;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Ticks are spaced by at least nine clocks
   AST_PCT_GAP: assert property (
      r_r.pct |=> !r_r.pct [*8])
      else $error("step ticks too close");
endmodule : shd_timebase

// File: rtl/shd_top.sv
// Contract
// - Enable high operates, low disables device
// - Serial access only 0.5ms after enable
// - Low/high side, parallel or full bridge
// - Current regulation only on low side
// - High side uses voltage regulation only
// - Voltage mode duty equals programmed value; code clamps 1-3 percent to 4 and 96-99 to 96
// - Current mode matches peak to reference
// - Per-channel config word sets levels, time
// - Channels run independently
// - Source bit picks on-bit or trigger
// - Even channels trigger even, odd odd
// - Activation: delay, hit target, start timer
// - Current mode ramps at maximum duty
// - Timer expiry moves to hold automatically
// - Current mode falls at minimum on-time
// - Deactivation ends the sequence at once
// - Oscillator 100 or 80 kHz selectable
// - Chop divider field divides oscillator
// - Fault pin plus readable fault register
// - Drive mode resets to current regulation
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "shd_params.svh"
module shd_top
#(
   parameter int unsigned WAKE_CYC = int'(`SHD_WAKE_MS * real'(`SHD_CLK_KHZ))
)
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        enable_pin,
   input  wire logic        trigger_in_even,
   input  wire logic        trigger_in_odd,
   input  wire logic [7:0]  cur_above,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             spi_ready,
   output logic [7:0]       drive,
   output logic [7:0]       high_side,
   output logic [7:0]       hit_target,
   output logic [55:0]      ref_code,
   output logic             fault_n
);
   // ****************************************
   // State and time base
   // ****************************************
   shd_pkg::shd_top_st_t r_r;   // Registered state
   shd_pkg::shd_top_st_t r_nxt; // Next state
   logic [7:0]           act;   // Channel requested on
   shd_tb_if             tb_if ();
   // Divider stops while disabled to save power
   assign tb_if.run      = r_r.en_s2;
   assign tb_if.freq_sel = r_r.freq;
   shd_timebase u_tb
   (
      .clk  (clk),
      .srst (srst),
      .tb   (tb_if.src)
   );
   // ****************************************
   // Activation source
   // ****************************************
   // Serial on-bits count only once the port is up
   always_comb
   begin
      for (int c = 0; c < 8; c++)
      begin
         if (r_r.cfg[c][`SHD_CF_SRC])
            act[c] = r_r.en_s2 & ((c % 2 == 0) ? r_r.te_s2 : r_r.to_s2);
         else
            act[c] = r_r.en_s2 & r_r.ready & r_r.on_bits[c];
      end
   end
   // ****************************************
   // Next state
   // ****************************************
   // Whole block is one registered image
   always_comb
   begin
      logic [8:0] len;     // Chop period in steps
      logic       wrap;    // Last step of a chop period
      logic       vmode;   // Effective voltage mode
      logic       hit_ph;  // In an excitation phase
      logic       cs;      // Current at or over target
      logic [1:0] sel;     // Divider field
      logic [6:0] lvl;     // Active level field
      logic [8:0] c_min;   // Minimum on-count
      logic [8:0] c_max;   // Maximum on-count
      logic [8:0] c_lvl;   // Programmed on-count
      logic       d;       // Raw drive of a channel
      logic       rd_flt;  // Fault register read
      logic [7:0] f_set;   // New fault events
      len = '0;
      wrap = 1'b0;
      vmode = 1'b0;
      hit_ph = 1'b0;
      cs = 1'b0;
      sel = '0;
      lvl = '0;
      c_min = '0;
      c_max = '0;
      c_lvl = '0;
      d = 1'b0;
      rd_flt = 1'b0;
      f_set = '0;
      r_nxt = r_r;
      // Pin synchronisers, stage one feeds stage two only
      r_nxt.en_s1 = enable_pin;
      r_nxt.en_s2 = r_r.en_s1;
      r_nxt.te_s1 = trigger_in_even;
      r_nxt.te_s2 = r_r.te_s1;
      r_nxt.to_s1 = trigger_in_odd;
      r_nxt.to_s2 = r_r.to_s1;
      r_nxt.cs_s1 = cur_above;
      r_nxt.cs_s2 = r_r.cs_s1;
      // Wake-up timer restarts on every enable
      if (!r_r.en_s2)
      begin
         r_nxt.wake = '0;
         r_nxt.ready = 1'b0;
      end
      else if (!r_r.ready)
      begin
         r_nxt.wake = r_r.wake + 20'h00001;
         r_nxt.ready = (r_r.wake >= 20'(WAKE_CYC - 1));
      end
      // Writes before wake-up are dropped
      if (reg_wr && r_r.ready)
      begin
         if (reg_addr == `SHD_A_STATUS)
         begin
            r_nxt.on_bits = reg_wdata[7:0];
            r_nxt.freq = reg_wdata[`SHD_ST_FREQ];
         end
         else if (shd_pkg::is_cfg(reg_addr))
            r_nxt.cfg[shd_pkg::cfg_idx(reg_addr)] = reg_wdata;
      end
      // Read data, zero when unmapped or asleep
      r_nxt.rdata = '0;
      if (reg_rd && r_r.ready)
      begin
         if (reg_addr == `SHD_A_STATUS)
         begin
            r_nxt.rdata[7:0] = r_r.on_bits;
            r_nxt.rdata[`SHD_ST_FREQ] = r_r.freq;
            r_nxt.rdata[`SHD_ST_READY] = r_r.ready;
         end
         else if (shd_pkg::is_cfg(reg_addr))
            r_nxt.rdata = r_r.cfg[shd_pkg::cfg_idx(reg_addr)];
         else if (reg_addr == `SHD_A_FAULT)
         begin
            r_nxt.rdata[7:0] = r_r.fault;
            rd_flt = 1'b1;
         end
      end
      // Each channel has its own sequence
      for (int c = 0; c < 8; c++)
      begin
         // High side forces voltage mode
         vmode = r_r.cfg[c][`SHD_CF_MODE] | r_r.cfg[c][`SHD_CF_HS];
         cs = r_r.cs_s2[c];
         sel = r_r.cfg[c][`SHD_CF_DIV +: 2];
         len = shd_pkg::chop_len(sel);
         wrap = tb_if.pct_tick && (r_r.phase[c] >= len - 9'h001);
         hit_ph = (r_r.ph[c] == shd_pkg::PH_RAMP) || (r_r.ph[c] == shd_pkg::PH_HIT);
         lvl = hit_ph ? r_r.cfg[c][`SHD_CF_HIT +: 7] : r_r.cfg[c][`SHD_CF_HOLD +: 7];
         c_min = shd_pkg::duty_cnt(`SHD_MIN_DUTY, sel);
         c_max = shd_pkg::duty_cnt(`SHD_MAX_DUTY, sel);
         c_lvl = shd_pkg::duty_cnt(lvl, sel);
         // Chop phase restarts at every activation
         if ((r_r.ph[c] == shd_pkg::PH_IDLE) || (r_r.ph[c] == shd_pkg::PH_DLY))
            r_nxt.phase[c] = '0;
         else if (tb_if.pct_tick)
            r_nxt.phase[c] = wrap ? 9'h000 : r_r.phase[c] + 9'h001;
         case (r_r.ph[c])
            shd_pkg::PH_IDLE:
            begin
               // Arm delay and hit timer together
               if (act[c])
               begin
                  r_nxt.ph[c] = shd_pkg::PH_DLY;
                  r_nxt.dly[c] = '0;
                  r_nxt.thit[c] = r_r.cfg[c][`SHD_CF_THIT +: 8];
               end
            end
            shd_pkg::PH_DLY:
            begin
               // Short turn-on delay
               if (r_r.dly[c] == 2'(`SHD_ACT_DLY_CYC - 3'h1))
                  r_nxt.ph[c] = vmode ? shd_pkg::PH_HIT : shd_pkg::PH_RAMP;
               else
                  r_nxt.dly[c] = r_r.dly[c] + 2'h1;
            end
            shd_pkg::PH_RAMP, shd_pkg::PH_HIT:
            begin
               // Ramp ends at first reach of hit level
               if ((r_r.ph[c] == shd_pkg::PH_RAMP) && cs)
                  r_nxt.ph[c] = shd_pkg::PH_HIT;
               // Timer moves once per chop period
               if (wrap)
               begin
                  if (r_r.thit[c] == 8'h00)
                  begin
                     // Hit never reached is a fault
                     if ((r_r.ph[c] == shd_pkg::PH_RAMP) && !cs)
                        f_set[c] = 1'b1;
                     r_nxt.ph[c] = vmode ? shd_pkg::PH_HOLD : shd_pkg::PH_FALL;
                  end
                  else
                     r_nxt.thit[c] = r_r.thit[c] - 8'h01;
               end
            end
            shd_pkg::PH_FALL:
            begin
               // Wait for decay to hold level
               if (!cs)
                  r_nxt.ph[c] = shd_pkg::PH_HOLD;
            end
            shd_pkg::PH_HOLD:
            begin
               // Hold until the host releases
               r_nxt.ph[c] = shd_pkg::PH_HOLD;
            end
            default:
            begin
               // Illegal code recovers to idle
               r_nxt.ph[c] = shd_pkg::PH_IDLE;
            end
         endcase
         // Release wins over every phase
         if (!act[c])
            r_nxt.ph[c] = shd_pkg::PH_IDLE;
         // Peak control: on at period start, off at target
         r_nxt.pon[c] = (r_r.phase[c] == 9'h000)
                      | (r_r.pon[c] & ~((cs & (r_r.phase[c] >= c_min)) | (r_r.phase[c] >= c_max)));
         case (r_r.ph[c])
            shd_pkg::PH_RAMP: d = r_r.phase[c] < c_max;
            shd_pkg::PH_FALL: d = r_r.phase[c] < c_min;
            shd_pkg::PH_HIT, shd_pkg::PH_HOLD:
               d = vmode ? (r_r.phase[c] < c_lvl) : r_r.pon[c];
            default: d = 1'b0;
         endcase
         r_nxt.drv[c] = d & (r_nxt.ph[c] != shd_pkg::PH_IDLE);
         r_nxt.hs[c] = r_r.cfg[c][`SHD_CF_HS];
         r_nxt.hitt[c] = hit_ph;
         r_nxt.refc[c] = vmode ? 7'h00 : lvl;
      end
      // Pairing: odd half-bridge follows, complements or ignores its even partner
      for (int p = 0; p < 4; p++)
      begin
         case (shd_pkg::shd_br_t'(r_r.cfg[2 * p][`SHD_CF_BR +: 2]))
            shd_pkg::BR_PAR:
            begin
               // Parallel doubles the current
               r_nxt.drv[2 * p + 1] = r_nxt.drv[2 * p];
               r_nxt.hs[2 * p + 1] = r_nxt.hs[2 * p];
            end
            shd_pkg::BR_FULL:
            begin
               // Opposite leg complements the even leg
               r_nxt.drv[2 * p + 1] = (r_nxt.ph[2 * p] != shd_pkg::PH_IDLE) & ~r_nxt.drv[2 * p];
               r_nxt.hs[2 * p + 1] = ~r_nxt.hs[2 * p];
            end
            default:
            begin
               // Independent half-bridges
               r_nxt.hs[2 * p + 1] = r_nxt.hs[2 * p + 1];
            end
         endcase
      end
      // Sticky faults, a new event beats clear-on-read
      r_nxt.fault = (r_r.fault & ~{8{rd_flt}}) | f_set;
      r_nxt.fault_n = ~|r_nxt.fault;
   end
   // ****************************************
   // State register
   // ****************************************
   // Reset image selects current mode everywhere
   always_ff @(posedge clk)
   begin
      if (srst)
         r_r <= shd_pkg::top_rst();
      else
         r_r <= r_nxt;
   end
   assign reg_rdata  = r_r.rdata;
   assign spi_ready  = r_r.ready;
   assign drive      = r_r.drv;
   assign high_side  = r_r.hs;
   assign hit_target = r_r.hitt;
   assign ref_code   = r_r.refc;
   assign fault_n    = r_r.fault_n;
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_arm0;
      (r_r.ph[0] == shd_pkg::PH_IDLE) && act[0];
   endsequence
   sequence s_held0;
      act[0] [*4];
   endsequence
   AST_WAKE: assert property (
      $rose(r_r.en_s2) |-> !spi_ready [*8])
      else $error("serial port ready too early");
   AST_NO_EARLY_WR: assert property (
      (reg_wr && !spi_ready) |=> (r_r.cfg == $past(r_r.cfg)) && (r_r.on_bits == $past(r_r.on_bits)))
      else $error("write taken before wake-up");
   AST_RD_STATUS: assert property (
      (reg_rd && spi_ready && (reg_addr == `SHD_A_STATUS)) |=> (reg_rdata[7:0] == $past(r_r.on_bits)))
      else $error("status read wrong");
   AST_DISABLE: assert property (
      !r_r.en_s2 |=> (drive == 8'h00) && !spi_ready)
      else $error("drive while disabled");
   AST_TRIG_EVEN: assert property (
      (r_r.en_s2 && r_r.cfg[2][`SHD_CF_SRC] && r_r.te_s2 && (r_r.ph[2] == shd_pkg::PH_IDLE))
      |=> (r_r.ph[2] == shd_pkg::PH_DLY))
      else $error("even trigger missed");
   AST_TRIG_ODD: assert property (
      (r_r.en_s2 && r_r.cfg[3][`SHD_CF_SRC] && r_r.to_s2 && (r_r.ph[3] == shd_pkg::PH_IDLE))
      |=> (r_r.ph[3] == shd_pkg::PH_DLY))
      else $error("odd trigger missed");
   AST_HS_VOLT: assert property (
      r_r.cfg[7][`SHD_CF_HS] |-> (r_r.ph[7] != shd_pkg::PH_DLY) or ##1 (r_r.ph[7] != shd_pkg::PH_RAMP))
      else $error("current mode on high side");
   AST_HIT_START: assert property (
      s_arm0 ##1 s_held0 |=> ((r_r.ph[0] == shd_pkg::PH_RAMP) || (r_r.ph[0] == shd_pkg::PH_HIT)))
      else $error("excitation not started after delay");
   AST_HOLD_AUTO: assert property (
      ((r_r.ph[6] == shd_pkg::PH_HIT) && (r_r.thit[6] == 8'h00) && tb_if.pct_tick
       && (r_r.phase[6] >= shd_pkg::chop_len(r_r.cfg[6][`SHD_CF_DIV +: 2]) - 9'h001) && act[6])
      |=> ((r_r.ph[6] == shd_pkg::PH_HOLD) || (r_r.ph[6] == shd_pkg::PH_FALL)))
      else $error("no automatic hold");
   AST_DEACT: assert property (
      ((r_r.ph[0] != shd_pkg::PH_IDLE) && !act[0]) |=> (r_r.ph[0] == shd_pkg::PH_IDLE) && !drive[0])
      else $error("release did not end drive");
   AST_FAULT_PIN: assert property (
      $rose(r_r.fault[4]) |-> !fault_n ##1 (!fault_n || $past(reg_rd)))
      else $error("fault pin not low");
endmodule : shd_top

// File: sim/shd_host.sv
`timescale 1ns/100ps
// *****
// Host model: register master
// *****
module shd_host
(
   input  wire logic        clk,
   input  wire logic        rdy,
   input  wire logic [31:0] rdata,
   output logic [7:0]       addr,
   output logic [31:0]      wdata,
   output logic             wr,
   output logic             rd
);
   // Bus idle from time zero
   initial
   begin
      addr  = 8'h00;
      wdata = 32'h0000_0000;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // No transfer until the port has woken
   task automatic wait_rdy();
      while (rdy !== 1'b1)
         @(posedge clk);
   endtask : wait_rdy
   // Write strobe, then one idle cycle so strobes never merge
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      @(posedge clk);
   endtask : put
   // Read strobe; data taken in the following cycle only
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : get
endmodule : shd_host

// File: sim/tb_solenoid_hit_hold_drive_sequencer.sv
`timescale 1ns/100ps
`include "shd_params.svh"
// *****
// Bench top
// *****
module tb_solenoid_hit_hold_drive_sequencer;
   localparam int WAKE = 16;            // Short wake span keeps the run brief
   logic        clk = 1'b0;             // 200 MHz
   logic        srst;                   // Sync reset
   logic        enable_pin;             // Device enable
   logic        trg_e;                  // Even trigger pin
   logic        trg_o;                  // Odd trigger pin
   logic [7:0]  cur_above;              // Comparator levels
   logic [7:0]  reg_addr;               // Bus from host model
   logic        reg_wr;
   logic        reg_rd;
   logic        spi_ready;
   logic        fault_n;
   logic [31:0] reg_wdata, reg_rdata, rd, w;
   logic [7:0]  drive, high_side, hit_target, mask, hs;
   logic [55:0] ref_code;
   int          errors, n_compared, k, duty, f;

   always #2.5 clk = ~clk;

   shd_top #(.WAKE_CYC(WAKE)) dut
   (
      .clk(clk), .srst(srst), .enable_pin(enable_pin), .trigger_in_even(trg_e), .trigger_in_odd(trg_o),
      .cur_above(cur_above), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .spi_ready(spi_ready), .drive(drive), .high_side(high_side),
      .hit_target(hit_target), .ref_code(ref_code), .fault_n(fault_n)
   );
   shd_host host
   (
      .clk(clk), .rdy(spi_ready), .rdata(reg_rdata), .addr(reg_addr), .wdata(reg_wdata),
      .wr(reg_wr), .rd(reg_rd)
   );
   // Compare and count
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp
   // Verdict and end of run
   task automatic test_done();
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // Build and write one channel word; kept in w for read-back
   task automatic cset(input int c, input logic [6:0] hi, input logic [6:0] ho, input logic [7:0] t,
                       input logic [1:0] dv, input logic vm, input logic src, input logic h);
      w = {3'h0, h, src, vm, dv, t, 1'b0, ho, 1'b0, hi};
      host.put(8'(`SHD_A_CFG0 + 4 * c), w);
   endtask : cset
   // Expected high clocks per chop period, duty clamped to the window
   function automatic int exp_on(input int p, input int dv, input int stp);
      if (p >= 100)
         p = 100;
      else if (p >= 96)
         p = 96;
      else if (p > 0 && p < 4)
         p = 4;
      return p * (4 - dv) * stp;
   endfunction : exp_on
   // Count high clocks of one drive bit
   task automatic ontime(input int c, input int len, output int n);
      n = 0;
      repeat (len)
      begin
         @(posedge clk);
         n += int'(drive[c]);
      end
   endtask : ontime
   // Watchdog, about twice the expected span
   initial
   begin
      repeat (80000) @(posedge clk);
      errors++;
      test_done();
   end
   // Main sequence
   initial
   begin
      srst = 1'b1;
      enable_pin = 1'b0;
      trg_e = 1'b0;
      trg_o = 1'b0;
      cur_above = 8'h00;
      errors = 0;
      n_compared = 0;
      void'($urandom(61953));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      cmp(32'({fault_n, spi_ready, drive}), 32'h200, "reset");
      enable_pin <= 1'b1;
      host.put(`SHD_A_STATUS, 32'h0000_00FF);
      repeat (WAKE - 4) @(posedge clk);
      cmp(32'(spi_ready), 32'h0, "early ready");
      host.wait_rdy();
      host.get(`SHD_A_STATUS, rd);
      cmp(rd, 32'h0000_0200, "status");
      host.get(`SHD_A_CFG0, rd);
      cmp(rd, 32'h0, "cfg reset");
      host.put(8'h30, 32'hFFFF_FFFF);
      host.get(8'h30, rd);
      cmp(rd, 32'h0, "unmapped");
      // Random on-bit masks, full duty, random side
      hs = 8'($urandom);
      for (int c = 0; c < 8; c++)
         cset(c, 7'h64, 7'h64, 8'hFF, 2'h3, 1'b1, 1'b0, hs[c]);
      for (int i = 0; i < 6; i++)
      begin
         mask = (i == 0) ? 8'hFF : 8'($urandom);
         host.put(`SHD_A_STATUS, {24'h0, mask});
         repeat (10) @(posedge clk);
         cmp(32'({drive, hit_target}), 32'({mask, mask}), "on-bits");
         cmp(32'(high_side), 32'(hs), "side");
      end
      // Trigger source ignores on-bits
      host.put(`SHD_A_STATUS, 32'h0);
      cset(2, 7'h64, 7'h64, 8'hFF, 2'h3, 1'b1, 1'b1, 1'b0);
      cset(3, 7'h64, 7'h64, 8'hFF, 2'h3, 1'b1, 1'b1, 1'b0);
      host.put(`SHD_A_STATUS, 32'h0000_000C);
      repeat (10) @(posedge clk);
      cmp(32'(drive[3:2]), 32'h0, "src");
      trg_e <= 1'b1;
      repeat (10) @(posedge clk);
      cmp(32'(drive[3:2]), 32'h1, "even pin");
      trg_e <= 1'b0;
      trg_o <= 1'b1;
      repeat (10) @(posedge clk);
      cmp(32'(drive[3:2]), 32'h2, "odd pin");
      trg_o <= 1'b0;
      repeat (5) @(posedge clk);
      cmp(32'(drive[3:2]), 32'h0, "pin off");
      // Voltage duty over every divider code, random oscillator
      for (int i = 0; i < 4; i++)
      begin
         f = $urandom_range(0, 1);
         duty = (i == 0) ? 2 : (i == 3) ? 98 : $urandom_range(5, 95);
         cset(5, 7'(duty), 7'(duty), 8'hFF, 2'(i), 1'b1, 1'b0, 1'b0);
         host.get(8'h18, rd);
         cmp(rd, w, "cfg read");
         host.put(`SHD_A_STATUS, {23'h0, 1'(f), 8'h20});
         repeat (20) @(posedge clk);
         ontime(5, 100 * (4 - i) * (f ? 25 : 20), k);
         cmp(32'(k), 32'(exp_on(duty, i, f ? 25 : 20)), "duty");
         host.put(`SHD_A_STATUS, 32'h0);
      end
      // Hit time of two periods, zero hold duty
      cset(6, 7'h64, 7'h00, 8'h01, 2'h3, 1'b1, 1'b0, 1'b0);
      host.put(`SHD_A_STATUS, 32'h0000_0040);
      repeat (3800) @(posedge clk);
      cmp(32'({hit_target[6], drive[6]}), 32'h3, "still hit");
      repeat (400) @(posedge clk);
      cmp(32'({hit_target[6], drive[6]}), 32'h0, "hold");
      // Current mode: ramp, peak, fall
      host.put(`SHD_A_STATUS, 32'h0);
      cset(4, 7'h50, 7'h10, 8'h02, 2'h3, 1'b0, 1'b0, 1'b0);
      host.put(`SHD_A_STATUS, 32'h0000_0010);
      repeat (30) @(posedge clk);
      cmp(32'({hit_target[4], ref_code[34:28]}), 32'hD0, "hit ref");
      ontime(4, 2000, k);
      cmp(32'(k), 32'd1920, "ramp");
      cur_above[4] <= 1'b1;
      repeat (4500) @(posedge clk);
      cmp(32'({hit_target[4], ref_code[34:28]}), 32'h10, "hold ref");
      ontime(4, 2000, k);
      cmp(32'(k), 32'd80, "min on");
      // Hit level never reached: fault, clear on read
      cur_above[4] <= 1'b0;
      host.put(`SHD_A_STATUS, 32'h0);
      cset(4, 7'h50, 7'h10, 8'h00, 2'h3, 1'b0, 1'b0, 1'b0);
      host.put(`SHD_A_STATUS, 32'h0000_0010);
      repeat (2300) @(posedge clk);
      cmp(32'(fault_n), 32'h0, "fault pin");
      host.get(`SHD_A_FAULT, rd);
      cmp(rd, 32'h10, "fault bits");
      host.get(`SHD_A_FAULT, rd);
      cmp({rd[31:1], fault_n}, 32'h1, "fault clear");
      // High side asked for current mode runs voltage mode
      host.put(`SHD_A_STATUS, 32'h0);
      cset(7, 7'h32, 7'h32, 8'hFF, 2'h3, 1'b0, 1'b0, 1'b1);
      host.put(`SHD_A_STATUS, 32'h0000_0080);
      repeat (20) @(posedge clk);
      cmp(32'(ref_code[55:49]), 32'h0, "hs ref");
      ontime(7, 2000, k);
      cmp(32'(k), 32'(exp_on(50, 3, 20)), "hs duty");
      // Pair modes on channels 0 and 1: parallel, then full bridge
      for (int i = 1; i < 3; i++)
      begin
         host.put(`SHD_A_CFG0, {1'b0, 2'(i), 29'h07FF_0064});
         host.put(`SHD_A_STATUS, 32'h0000_0001);
         repeat (10) @(posedge clk);
         cmp(32'({high_side[1:0], drive[1:0]}), (i == 1) ? 32'h3 : 32'h9, "pair");
         host.put(`SHD_A_STATUS, 32'h0);
      end
      enable_pin <= 1'b0;
      repeat (5) @(posedge clk);
      cmp(32'({spi_ready, drive}), 32'h0, "disabled");
      test_done();
   end
endmodule : tb_solenoid_hit_hold_drive_sequencer
